// ===== scg_map.svh
// address map, field positions, reset values and timing counts of the clock block
`ifndef SCG_MAP_SVH
`define SCG_MAP_SVH
`define SCG_ADDR_STATUS       32'hffff0400
`define SCG_ADDR_POW_PRE      32'hffff0404
`define SCG_ADDR_POW          32'hffff0408
`define SCG_ADDR_POW_POST     32'hffff040c
`define SCG_ADDR_SRC_PRE      32'hffff0410
`define SCG_ADDR_SRC          32'hffff0414
`define SCG_ADDR_SRC_POST     32'hffff0418
`define SCG_KEY_SRC_PRE       32'h000000aa
`define SCG_KEY_SRC_POST      32'h00000055
`define SCG_KEY_POW_PRE       32'h00000001
`define SCG_KEY_POW_POST      32'h000000f4
`define SCG_POW_RESET         8'h79
`define SCG_SRC_RESET         2'h0
`define SCG_SRC_W             2
`define SCG_POW_W             8
`define SCG_STAT_XTAL_BIT     2
`define SCG_STAT_LOCK_BIT     1
`define SCG_STAT_FLAG_BIT     0
`define SCG_SRC_LPOSC         2'h0
`define SCG_SRC_PREC          2'h1
`define SCG_SRC_XTAL          2'h2
`define SCG_SRC_RSVD          2'h3
`define SCG_OSC_DIV           4
`define SCG_PLL_MULT          625
`define SCG_PRELOCK_DIV       8
`define SCG_PLL_KHZ           20480
`define SCG_ADC_KHZ           512
`define SCG_ADC_DIV           (`SCG_PLL_KHZ / `SCG_ADC_KHZ)
`define SCG_CLK_PERIOD_NS     10
`define SCG_LOCK_TIME_US      2000
`define SCG_LOCK_TIMEOUT_CYC  ((`SCG_LOCK_TIME_US * 1000) / `SCG_CLK_PERIOD_NS)
`define SCG_LOCK_REFS         4
`define SCG_LOCK_TOL          2
`endif

// ===== scg_pkg.sv
// types shared by the clock generation block
package scg_pkg;
    typedef enum {
        KEY_IDLE,
        KEY_ARMED,
        KEY_HELD
    } scg_key_state_t;

    typedef struct packed {
        logic       precEn;
        logic       xtalEn;
        logic       pllOn;
        logic       periphOn;
        logic       coreOn;
        logic [2:0] cd;
    } scg_power_t;

    typedef struct packed {
        logic [4:0] rsvd;
        logic       xtalLevel;
        logic       locked;
        logic       lockFallFlag;
    } scg_status_t;
endpackage

// ===== scg_tick_div.sv
// tick divider: one output pulse for every divisor input ticks
`timescale 1ns/100ps
`default_nettype none
module scg_tick_div #(
    parameter int CNT_W = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             enable,
    input  wire logic             tickIn,
    input  wire logic [CNT_W-1:0] divisor,
    output logic                  tickOut
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             tick_q;
    logic             tick_d;

    if (CNT_W < 1) begin : g_bad
        $error("scg_tick_div: CNT_W must be at least 1");
    end

    // compare with >= so a shrinking divisor never strands the counter
    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (!enable) begin
            cnt_d = '0;
        end else if (tickIn) begin
            if (cnt_q >= divisor - CNT_W'(1)) begin
                cnt_d  = '0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tickOut = tick_q;
endmodule // scg_tick_div
`default_nettype wire

// ===== scg_system_clock_generation.sv
// system clock generation: source select, lock tracking, dividers, keyed registers
//
// Behaviour
// - reference from one of three sources
// - internal oscillators divided by four
// - PLL output is 625 ticks per reference period
// - reset selects low power oscillator
// - core clock via divider, default two
// - divider 1 to 128, changeable anytime
// - ADC clock 512k, low power uses oscillator
// - timer tick is low power oscillator/4
// - low power oscillator always enabled
// - divide by eight until PLL locks
// - lock expected within 2 ms
// - source register needs both keys
// - power register needs both keys
// - status bit 2 is live crystal pin
// - status bit 1 shows lock
// - status bit 0 set on lock fall, W1C
// - source and power registers steer clocks
// - source codes 00, 01, 10; 11 reserved
// - PLL enable set at reset and wake
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "scg_map.svh"
module scg_system_clock_generation #(
    parameter int LOCK_TIMEOUT_CYC = `SCG_LOCK_TIMEOUT_CYC,
    parameter int LOCK_REFS        = `SCG_LOCK_REFS,
    parameter int LOCK_TOL         = `SCG_LOCK_TOL
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        lpOscTick,
    input  wire logic        precOscTick,
    input  wire logic        crystalInputPin,
    input  wire logic        pllOscTick,
    input  wire logic        wakeEvent,
    input  wire logic        adcLowPower,
    output logic             pllRefTick,
    output logic             pllEnable,
    output logic             pllLocked,
    output logic             pllLockLate,
    output logic             coreClkTick,
    output logic             adcClkTick,
    output logic             timerClkTick,
    output logic             lpOscEnable,
    output logic             precOscEnable,
    output logic             xtalEnable,
    output logic             periphEnable,
    output logic             coreEnable,
    output logic      [1:0]  sourceSelect
);
    localparam int CNT_W = 20;

    if (LOCK_TIMEOUT_CYC < 1 || LOCK_TIMEOUT_CYC >= (1 << CNT_W)) begin : g_bad_timeout
        $error("LOCK_TIMEOUT_CYC out of range");
    end
    if (LOCK_REFS < 1 || LOCK_REFS > 15 || LOCK_TOL < 0 || LOCK_TOL > 64) begin : g_bad_lock
        $error("LOCK_REFS or LOCK_TOL out of range");
    end

    // apb decode
    logic wr;
    logic setup;
    logic isStatus;
    logic isPowPre;
    logic isPow;
    logic isPowPost;
    logic isSrcPre;
    logic isSrc;
    logic isSrcPost;
    logic mapped;

    assign wr        = psel && penable && pwrite;
    assign setup     = psel && !penable;
    assign isStatus  = (paddr == `SCG_ADDR_STATUS);
    assign isPowPre  = (paddr == `SCG_ADDR_POW_PRE);
    assign isPow     = (paddr == `SCG_ADDR_POW);
    assign isPowPost = (paddr == `SCG_ADDR_POW_POST);
    assign isSrcPre  = (paddr == `SCG_ADDR_SRC_PRE);
    assign isSrc     = (paddr == `SCG_ADDR_SRC);
    assign isSrcPost = (paddr == `SCG_ADDR_SRC_POST);
    assign mapped    = isStatus | isPowPre | isPow | isPowPost | isSrcPre | isSrc | isSrcPost;
    assign pready    = 1'b1;

    // any write that breaks the key, register, key sequence drops it
    function automatic scg_pkg::scg_key_state_t keyNext(
        input scg_pkg::scg_key_state_t st,
        input logic                    pre,
        input logic                    target,
        input logic                    post
    );
        scg_pkg::scg_key_state_t nx;
        nx = pre ? scg_pkg::KEY_ARMED : scg_pkg::KEY_IDLE;
        unique case (st)
            scg_pkg::KEY_IDLE:  nx = pre ? scg_pkg::KEY_ARMED : scg_pkg::KEY_IDLE;
            scg_pkg::KEY_ARMED: nx = target ? scg_pkg::KEY_HELD :
                                     (pre ? scg_pkg::KEY_ARMED : scg_pkg::KEY_IDLE);
            scg_pkg::KEY_HELD:  nx = post ? scg_pkg::KEY_IDLE :
                                     (pre ? scg_pkg::KEY_ARMED : scg_pkg::KEY_IDLE);
        endcase
        return nx;
    endfunction

    // keyed registers
    scg_pkg::scg_key_state_t powKey_q;
    scg_pkg::scg_key_state_t powKey_d;
    scg_pkg::scg_key_state_t srcKey_q;
    scg_pkg::scg_key_state_t srcKey_d;
    scg_pkg::scg_power_t     pow_q;
    scg_pkg::scg_power_t     pow_d;
    scg_pkg::scg_power_t     powHold_q;
    scg_pkg::scg_power_t     powHold_d;
    logic [1:0]              src_q;
    logic [1:0]              src_d;
    logic [1:0]              srcHold_q;
    logic [1:0]              srcHold_d;
    logic                    powPreOk;
    logic                    powPostOk;
    logic                    srcPreOk;
    logic                    srcPostOk;

    assign powPreOk  = isPowPre && (pwdata == `SCG_KEY_POW_PRE);
    assign powPostOk = isPowPost && (pwdata == `SCG_KEY_POW_POST);
    assign srcPreOk  = isSrcPre && (pwdata == `SCG_KEY_SRC_PRE);
    assign srcPostOk = isSrcPost && (pwdata == `SCG_KEY_SRC_POST);

    always_comb begin
        powKey_d  = powKey_q;
        powHold_d = powHold_q;
        pow_d     = pow_q;
        srcKey_d  = srcKey_q;
        srcHold_d = srcHold_q;
        src_d     = src_q;
        if (wr) begin
            powKey_d = keyNext(powKey_q, powPreOk, isPow, powPostOk);
            srcKey_d = keyNext(srcKey_q, srcPreOk, isSrc, srcPostOk);
            if (powKey_q == scg_pkg::KEY_ARMED && isPow) begin
                powHold_d = scg_pkg::scg_power_t'(pwdata[7:0]);
            end
            if (srcKey_q == scg_pkg::KEY_ARMED && isSrc) begin
                srcHold_d = pwdata[1:0];
            end
            // commit only on the postwrite key after a held value
            if (powKey_q == scg_pkg::KEY_HELD && powPostOk) begin
                pow_d = powHold_q;
            end
            // the reserved code is dropped, source stays as it was
            if (srcKey_q == scg_pkg::KEY_HELD && srcPostOk && srcHold_q != `SCG_SRC_RSVD) begin
                src_d = srcHold_q;
            end
        end
        // wake beats a same-cycle software power-down
        if (wakeEvent) begin
            pow_d.pllOn    = 1'b1;
            pow_d.periphOn = 1'b1;
            pow_d.coreOn   = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            powKey_q  <= scg_pkg::KEY_IDLE;
            srcKey_q  <= scg_pkg::KEY_IDLE;
            pow_q     <= scg_pkg::scg_power_t'(`SCG_POW_RESET);
            powHold_q <= scg_pkg::scg_power_t'(`SCG_POW_RESET);
            src_q     <= `SCG_SRC_RESET;
            srcHold_q <= `SCG_SRC_RESET;
        end else begin
            powKey_q  <= powKey_d;
            srcKey_q  <= srcKey_d;
            pow_q     <= pow_d;
            powHold_q <= powHold_d;
            src_q     <= src_d;
            srcHold_q <= srcHold_d;
        end
    end

    // reference generation
    logic lpRefTick;
    logic precRefTick;
    logic xtalPrev_q;
    logic xtalTick;
    logic refTick_q;
    logic refTick_d;

    scg_tick_div #(.CNT_W(3)) u_lp_div (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .enable  (1'b1),
        .tickIn  (lpOscTick),
        .divisor (3'(`SCG_OSC_DIV)),
        .tickOut (lpRefTick)
    );

    scg_tick_div #(.CNT_W(3)) u_prec_div (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .enable  (pow_q.precEn),
        .tickIn  (precOscTick),
        .divisor (3'(`SCG_OSC_DIV)),
        .tickOut (precRefTick)
    );

    assign xtalTick = crystalInputPin && !xtalPrev_q && pow_q.xtalEn;

    always_comb begin
        unique case (src_q)
            `SCG_SRC_LPOSC: refTick_d = lpRefTick;
            `SCG_SRC_PREC:  refTick_d = precRefTick;
            `SCG_SRC_XTAL:  refTick_d = xtalTick;
            default:        refTick_d = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            xtalPrev_q <= 1'b0;
            refTick_q  <= 1'b0;
        end else begin
            xtalPrev_q <= crystalInputPin;
            refTick_q  <= refTick_d;
        end
    end

    // lock tracking: count oscillator ticks per reference period
    logic [9:0]       perCnt_q;
    logic [9:0]       perCnt_d;
    logic [3:0]       match_q;
    logic [3:0]       match_d;
    logic             locked_q;
    logic             locked_d;
    logic             inWindow;
    logic [CNT_W-1:0] lockTmr_q;
    logic [CNT_W-1:0] lockTmr_d;
    logic             late_q;
    logic             late_d;
    logic             pllOnPrev_q;

    assign inWindow = (int'(perCnt_q) >= `SCG_PLL_MULT - LOCK_TOL) &&
                      (int'(perCnt_q) <= `SCG_PLL_MULT + LOCK_TOL);

    always_comb begin
        perCnt_d = perCnt_q;
        match_d  = match_q;
        locked_d = locked_q;
        if (!pow_q.pllOn) begin
            perCnt_d = '0;
            match_d  = '0;
            locked_d = 1'b0;
        end else if (refTick_q) begin
            perCnt_d = {9'h000, pllOscTick};
            if (inWindow) begin
                if (int'(match_q) < LOCK_REFS) begin
                    match_d = match_q + 4'h1;
                end
                if (int'(match_q) + 1 >= LOCK_REFS) begin
                    locked_d = 1'b1;
                end
            end else begin
                match_d  = '0;
                locked_d = 1'b0;
            end
        end else if (pllOscTick && perCnt_q != 10'h3ff) begin
            perCnt_d = perCnt_q + 10'h001;
        end
    end

    // timer restarts each time the PLL is powered up
    always_comb begin
        lockTmr_d = lockTmr_q;
        late_d    = late_q;
        if (pow_q.pllOn && !pllOnPrev_q) begin
            lockTmr_d = '0;
            late_d    = 1'b0;
        end else if (pow_q.pllOn && !locked_q && !late_q) begin
            if (int'(lockTmr_q) >= LOCK_TIMEOUT_CYC - 1) begin
                late_d = 1'b1;
            end else begin
                lockTmr_d = lockTmr_q + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            perCnt_q    <= '0;
            match_q     <= '0;
            locked_q    <= 1'b0;
            lockTmr_q   <= '0;
            late_q      <= 1'b0;
            pllOnPrev_q <= 1'b0;
        end else begin
            perCnt_q    <= perCnt_d;
            match_q     <= match_d;
            locked_q    <= locked_d;
            lockTmr_q   <= lockTmr_d;
            late_q      <= late_d;
            pllOnPrev_q <= pow_q.pllOn;
        end
    end

    // core, adc and timer ticks
    logic       cdTick;
    logic       preLockTick;
    logic       adcDivTick;
    logic [7:0] cdDivisor;
    logic       core_q;
    logic       core_d;
    logic       adc_q;
    logic       adc_d;
    logic       tmr_q;

    assign cdDivisor = 8'h01 << pow_q.cd;

    scg_tick_div #(.CNT_W(8)) u_cd_div (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .enable  (locked_q),
        .tickIn  (pllOscTick),
        .divisor (cdDivisor),
        .tickOut (cdTick)
    );

    scg_tick_div #(.CNT_W(4)) u_prelock_div (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .enable  (pow_q.pllOn && !locked_q),
        .tickIn  (pllOscTick),
        .divisor (4'(`SCG_PRELOCK_DIV)),
        .tickOut (preLockTick)
    );

    scg_tick_div #(.CNT_W(6)) u_adc_div (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .enable  (pow_q.pllOn),
        .tickIn  (pllOscTick),
        .divisor (6'(`SCG_ADC_DIV)),
        .tickOut (adcDivTick)
    );

    // core runs before lock on the slow clock rather than waiting
    always_comb begin
        core_d = locked_q ? cdTick : preLockTick;
        adc_d  = adcLowPower ? lpOscTick : adcDivTick;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            core_q <= 1'b0;
            adc_q  <= 1'b0;
            tmr_q  <= 1'b0;
        end else begin
            core_q <= core_d;
            adc_q  <= adc_d;
            tmr_q  <= lpRefTick;
        end
    end

    // status flag and read path
    logic                 flag_q;
    logic                 flag_d;
    logic                 lockFell;
    scg_pkg::scg_status_t status;
    logic [31:0]          rdata_q;
    logic [31:0]          rdata_d;
    logic                 err_q;
    logic                 err_d;

    assign lockFell = pllLocked && !locked_q;

    always_comb begin
        flag_d = flag_q;
        if (wr && isStatus && pwdata[`SCG_STAT_FLAG_BIT]) begin
            flag_d = 1'b0;
        end
        if (lockFell) begin
            flag_d = 1'b1;
        end
    end

    always_comb begin
        status              = '0;
        status.xtalLevel    = crystalInputPin;
        status.locked       = locked_q;
        status.lockFallFlag = flag_q;
        rdata_d             = rdata_q;
        err_d               = err_q;
        // captured in setup so read data comes from a flop in the access phase
        if (setup) begin
            err_d   = !mapped;
            rdata_d = 32'h00000000;
            if (!pwrite) begin
                if (isStatus) rdata_d = {24'h000000, status};
                if (isPow)    rdata_d = {24'h000000, pow_q};
                if (isSrc)    rdata_d = {30'h00000000, src_q};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flag_q    <= 1'b0;
            rdata_q   <= 32'h00000000;
            err_q     <= 1'b0;
            pllLocked <= 1'b0;
        end else begin
            flag_q    <= flag_d;
            rdata_q   <= rdata_d;
            err_q     <= err_d;
            pllLocked <= locked_q;
        end
    end

    assign prdata        = rdata_q;
    assign pslverr       = err_q && psel && penable;
    assign pllRefTick    = refTick_q;
    assign pllEnable     = pow_q.pllOn;
    assign pllLockLate   = late_q;
    assign coreClkTick   = core_q;
    assign adcClkTick    = adc_q;
    assign timerClkTick  = tmr_q;
    assign lpOscEnable   = 1'b1;
    assign precOscEnable = pow_q.precEn;
    assign xtalEnable    = pow_q.xtalEn;
    assign periphEnable  = pow_q.periphOn;
    assign coreEnable    = pow_q.coreOn;
    assign sourceSelect  = src_q;
endmodule // scg_system_clock_generation
`default_nettype wire

// ===== scg_system_clock_generation_chk.sv
// concurrent checks on the ports of the system clock generation block
`timescale 1ns/100ps
`default_nettype none
`include "scg_map.svh"
module scg_system_clock_generation_chk (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic        pslverr,
    input wire logic        wakeEvent,
    input wire logic        pllEnable,
    input wire logic        pllLocked,
    input wire logic        coreClkTick,
    input wire logic        lpOscEnable,
    input wire logic        precOscEnable,
    input wire logic        xtalEnable,
    input wire logic        periphEnable,
    input wire logic        coreEnable,
    input wire logic [1:0]  sourceSelect
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    logic mapped;
    logic srcPost;
    logic powPost;
    logic [4:0] powBits;
    always_comb begin
        mapped = paddr inside {`SCG_ADDR_STATUS, `SCG_ADDR_POW_PRE, `SCG_ADDR_POW,
            `SCG_ADDR_POW_POST, `SCG_ADDR_SRC_PRE, `SCG_ADDR_SRC, `SCG_ADDR_SRC_POST};
        srcPost = psel && penable && pwrite && paddr == `SCG_ADDR_SRC_POST;
        powPost = psel && penable && pwrite && paddr == `SCG_ADDR_POW_POST;
        powBits = {precOscEnable, xtalEnable, pllEnable, periphEnable, coreEnable};
    end

    lposc_on_a: assert property (lpOscEnable)
        else $error("low power oscillator enable dropped");
    rst_default_a: assert property ($past(sys_rst) |->
        sourceSelect == `SCG_SRC_LPOSC && pllEnable)
        else $error("source or pll enable wrong after reset");
    src_keyed_a: assert property (!srcPost |=> $stable(sourceSelect))
        else $error("source select changed without post key");
    // the enables may lag the commit by one register stage
    pow_keyed_a: assert property (
        !powPost && !$past(powPost) && !wakeEvent && !$past(wakeEvent) |=> $stable(powBits))
        else $error("power enables changed without post key or wake");
    src_rsvd_a: assert property (sourceSelect != `SCG_SRC_RSVD)
        else $error("reserved source code committed");
    wake_up_a: assert property (wakeEvent |->
        ##[1:2] (pllEnable && periphEnable && coreEnable))
        else $error("wake did not restart pll, peripherals and core");
    err_unmapped_a: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    err_mapped_a: assert property (psel && penable && mapped |-> !pslverr)
        else $error("mapped access refused");
    core_gate_a: assert property ((!pllEnable)[*4] |-> !coreClkTick)
        else $error("core tick while pll is off");

    lock_c: cover property ($rose(pllLocked));
    unlock_c: cover property ($fell(pllLocked));
    wake_c: cover property (wakeEvent);
    xtal_c: cover property (sourceSelect == `SCG_SRC_XTAL);
endmodule // scg_system_clock_generation_chk

bind scg_system_clock_generation scg_system_clock_generation_chk u_chk (
    .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pslverr, .wakeEvent, .pllEnable,
    .pllLocked, .coreClkTick, .lpOscEnable, .precOscEnable, .xtalEnable, .periphEnable,
    .coreEnable, .sourceSelect
);
`default_nettype wire

// ===== tb.sv
// self-checking bench for the system clock generation block
`timescale 1ns/100ps
`default_nettype none
`include "scg_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, rerr;
    logic [31:0] paddr, pwdata, prdata, rdat;
    logic        lpOscTick, precOscTick, crystalInputPin, pllOscTick, wakeEvent, adcLowPower;
    logic        pllRefTick, pllEnable, pllLocked, pllLockLate, coreClkTick, adcClkTick;
    logic        timerClkTick, lpOscEnable, precOscEnable, xtalEnable, periphEnable, coreEnable;
    logic [1:0]  sourceSelect;
    int          cyc, xc, xper, fails, compares;
    int          cnt [4];
    // cd rows: power value written, core ticks in a 640 cycle window while locked
    localparam logic [7:0] ROW_D [8] = '{8'hf8, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hff, 8'hf9};
    localparam int         ROW_C [8] = '{640, 160, 80, 40, 20, 10, 5, 320};

    scg_system_clock_generation #(.LOCK_TIMEOUT_CYC(4000)) dut (
        .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .lpOscTick, .precOscTick, .crystalInputPin, .pllOscTick, .wakeEvent,
        .adcLowPower, .pllRefTick, .pllEnable, .pllLocked, .pllLockLate, .coreClkTick,
        .adcClkTick, .timerClkTick, .lpOscEnable, .precOscEnable, .xtalEnable, .periphEnable,
        .coreEnable, .sourceSelect
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // oscillator ticks; crystal period of xper cycles, pll tick every cycle
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        lpOscTick <= (cyc % 8) == 0;
        precOscTick <= (cyc % 16) == 0;
        if (xper != 0) begin
            xc <= (xc + 1 >= xper) ? 0 : xc + 1;
            crystalInputPin <= xc < xper / 2;
        end
        if (cyc == 60000) begin
            fails++;
            final_report();
        end
    end

    always @(negedge sys_clk) begin
        cnt[0] += coreClkTick;
        cnt[1] += pllRefTick;
        cnt[2] += timerClkTick;
        cnt[3] += adcClkTick;
    end

    task automatic final_report();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // waits on pready only; the run's cycle ceiling ends a hang
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic kw(input logic [31:0] a, input logic [31:0] d);
        logic pw;
        pw = a == `SCG_ADDR_POW;
        apb(1'b1, pw ? `SCG_ADDR_POW_PRE : `SCG_ADDR_SRC_PRE,
            pw ? `SCG_KEY_POW_PRE : `SCG_KEY_SRC_PRE);
        apb(1'b1, a, d);
        apb(1'b1, pw ? `SCG_ADDR_POW_POST : `SCG_ADDR_SRC_POST,
            pw ? `SCG_KEY_POW_POST : `SCG_KEY_SRC_POST);
        @(negedge sys_clk);
    endtask

    task automatic measure(input int n);
        @(posedge sys_clk);
        cnt = '{0, 0, 0, 0};
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wait_lock(input logic v);
        int n;
        n = 0;
        while (pllLocked !== v && n < 8000) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    initial begin
        {sys_rst, pllOscTick, adcLowPower} = 3'b111;
        {psel, penable, pwrite, wakeEvent, crystalInputPin, lpOscTick, precOscTick} = '0;
        {paddr, pwdata} = '0;
        {cyc, xc, xper, fails, compares} = '0;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        apb(1'b0, `SCG_ADDR_POW, 0);
        `CHK(rdat[7:0], 8'h79)
        apb(1'b0, `SCG_ADDR_STATUS, 0);
        `CHK(rdat[1:0], 2'h0)
        measure(640);
        `CHK(cnt[0], 80)
        `CHK(cnt[1], 20)
        `CHK(cnt[2], 20)
        `CHK(cnt[3], 80)
        kw(`SCG_ADDR_POW, 32'hf9);
        `CHK({precOscEnable, xtalEnable, pllEnable, periphEnable, coreEnable}, 5'h1f)
        kw(`SCG_ADDR_SRC, 32'h1);
        `CHK(sourceSelect, 2'h1)
        measure(640);
        `CHK(cnt[1], 10)
        kw(`SCG_ADDR_SRC, 32'h3);
        `CHK(sourceSelect, 2'h1)
        // a foreign write between the keys must break the sequence
        apb(1'b1, `SCG_ADDR_SRC_PRE, `SCG_KEY_SRC_PRE);
        apb(1'b1, `SCG_ADDR_STATUS, 0);
        apb(1'b1, `SCG_ADDR_SRC, 2);
        apb(1'b1, `SCG_ADDR_SRC_POST, `SCG_KEY_SRC_POST);
        `CHK(sourceSelect, 2'h1)
        apb(1'b1, `SCG_ADDR_POW_PRE, 2);
        apb(1'b1, `SCG_ADDR_POW, 0);
        apb(1'b1, `SCG_ADDR_POW_POST, `SCG_KEY_POW_POST);
        apb(1'b0, `SCG_ADDR_POW, 0);
        `CHK(rdat[7:0], 8'hf9)
        for (int v = 0; v < 2; v++) begin
            crystalInputPin <= v[0];
            repeat (4) @(posedge sys_clk);
            apb(1'b0, `SCG_ADDR_STATUS, 0);
            `CHK(rdat[2], v[0])
        end
        xper = 625;
        kw(`SCG_ADDR_SRC, 32'h2);
        `CHK(sourceSelect, 2'h2)
        wait_lock(1'b1);
        apb(1'b0, `SCG_ADDR_STATUS, 0);
        `CHK(rdat[1:0], 2'h2)
        for (int r = 0; r < 8; r++) begin
            kw(`SCG_ADDR_POW, {24'h0, ROW_D[r]});
            repeat (200) @(posedge sys_clk);
            measure(640);
            `CHK(cnt[0], ROW_C[r])
            apb(1'b0, `SCG_ADDR_POW, 0);
            `CHK(rdat[7:0], ROW_D[r])
        end
        adcLowPower <= 1'b0;
        measure(640);
        `CHK(cnt[3], 16)
        xper = 500;
        wait_lock(1'b0);
        repeat (3) @(posedge sys_clk);
        apb(1'b0, `SCG_ADDR_STATUS, 0);
        `CHK(rdat[1:0], 2'h1)
        apb(1'b1, `SCG_ADDR_STATUS, 1);
        apb(1'b0, `SCG_ADDR_STATUS, 0);
        `CHK(rdat[1:0], 2'h0)
        kw(`SCG_ADDR_SRC, 32'h0);
        `CHK(sourceSelect, 2'h0)
        kw(`SCG_ADDR_POW, 32'h0);
        `CHK(pllEnable, 1'b0)
        // the last pre-lock tick may still sit in the output flop
        repeat (2) @(posedge sys_clk);
        measure(64);
        `CHK(cnt[0], 0)
        wakeEvent <= 1'b1;
        @(posedge sys_clk);
        wakeEvent <= 1'b0;
        apb(1'b0, `SCG_ADDR_POW, 0);
        `CHK(rdat[7:0], 8'h38)
        apb(1'b0, 32'hffff0420, 0);
        `CHK(rerr, 1'b1)
        `CHK(pllLockLate, 1'b0)
        repeat (4000) @(posedge sys_clk);
        `CHK(pllLockLate, 1'b1)
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        apb(1'b0, `SCG_ADDR_POW, 0);
        `CHK(rdat[7:0], 8'h79)
        `CHK(sourceSelect, 2'h0)
        final_report();
    end
endmodule // tb
`default_nettype wire
